// *** posc_pkg.sv ***
// constants shared by the output steering and chopping stage
// assumes a 32-bit classic wishbone slave port and active-high pwm signals
package posc_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  // register byte offsets
  localparam logic [7:0] OFS_STEER = 8'h00;
  localparam logic [7:0] OFS_CHOP = 8'h04;
  localparam logic [7:0] OFS_UPDATE = 8'h08;
  localparam logic [7:0] OFS_ACTIVE = 8'h0C;
  localparam logic [7:0] WORD_MASK = 8'hFC;
  // register widths and reset values
  localparam int STEER_W = 9;
  localparam int CHOP_W = 16;
  localparam logic [8:0] STEER_RST = 9'h000;
  localparam logic [15:0] CHOP_RST = 16'h0000;
  localparam logic UPDATE_RST = 1'b0;
  // output_steer_disable fields
  localparam int XOVER_PAIR0_BIT = 8;
  localparam int XOVER_PAIR1_BIT = 7;
  localparam int XOVER_PAIR2_BIT = 6;
  localparam int DIS_PAIR2_HIGH_BIT = 0;
  localparam int DIS_PAIR2_LOW_BIT = 1;
  localparam int DIS_PAIR1_HIGH_BIT = 2;
  localparam int DIS_PAIR1_LOW_BIT = 3;
  localparam int DIS_PAIR0_HIGH_BIT = 4;
  localparam int DIS_PAIR0_LOW_BIT = 5;
  // gate_drive_chop_config fields
  localparam int CHOP_HIGH_BIT = 8;
  localparam int CHOP_LOW_BIT = 9;
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 7;
  localparam int DIV_W = 8;
  // update control field
  localparam int DBL_UPDATE_BIT = 0;
  // carrier counter covers half a period of 2*(div+1) cycles
  localparam int CNT_W = DIV_W + 1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
  // level of a pin in its off state
  localparam logic OUT_OFF = 1'b0;
endpackage

// *** posc_chop_carrier.sv ***
// chopping carrier generator with 50 percent duty
// assumes a divider value that may change at any time; the carrier adapts
`timescale 1ns/10ps
module posc_chop_carrier (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // divider field
  input wire logic [posc_pkg::DIV_W-1:0] i_chop_divider,
  // carrier out
  output logic o_carrier
);
  logic [posc_pkg::CNT_W-1:0] cnt;
  logic [posc_pkg::CNT_W-1:0] half_last;
  logic wrap;

  // half period is 2*(div+1) cycles, so full period is 4*(div+1)
  assign half_last = {i_chop_divider, 1'b1};
  assign wrap = (cnt >= half_last);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt <= posc_pkg::CNT_ZERO;
      o_carrier <= 1'b0;
    end else if (wrap) begin
      cnt <= posc_pkg::CNT_ZERO;
      o_carrier <= ~o_carrier;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule // posc_chop_carrier

// *** posc_top.sv ***
// output steering, disable and gate-drive chopping stage of a six-output pwm
// assumes timing-unit signals and sync pulses synchronous to i_clk
`timescale 1ns/10ps
module posc_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [posc_pkg::ADDR_W-1:0] i_wb_adr,
  input wire logic [posc_pkg::SEL_W-1:0] i_wb_sel,
  input wire logic [posc_pkg::DATA_W-1:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [posc_pkg::DATA_W-1:0] o_wb_dat,
  // timing unit signals
  input wire logic i_tu_pair0_high,
  input wire logic i_tu_pair0_low,
  input wire logic i_tu_pair1_high,
  input wire logic i_tu_pair1_low,
  input wire logic i_tu_pair2_high,
  input wire logic i_tu_pair2_low,
  // cycle synchronisation
  input wire logic i_cycle_sync_pulse,
  input wire logic i_cycle_mid_pulse,
  // output pins
  output logic o_pair0_high_pin,
  output logic o_pair0_low_pin,
  output logic o_pair1_high_pin,
  output logic o_pair1_low_pin,
  output logic o_pair2_high_pin,
  output logic o_pair2_low_pin
);
  // software-written shadow of the control word
  logic [posc_pkg::STEER_W-1:0] output_steer_disable;
  logic [posc_pkg::STEER_W-1:0] next_steer;
  // control word in force
  logic [posc_pkg::STEER_W-1:0] active_steer;
  // gate drive configuration
  logic [posc_pkg::CHOP_W-1:0] gate_drive_chop_config;
  logic [posc_pkg::CHOP_W-1:0] next_chop;
  // update mode
  logic double_update;
  logic next_double_update;
  // sync edge detection
  logic sync_prev;
  logic mid_prev;
  logic sync_rise;
  logic mid_rise;
  logic latch_now;

  // bus decode
  logic bus_req;
  logic wr_req;
  logic [posc_pkg::ADDR_W-1:0] word_adr;
  logic hit_steer;
  logic hit_chop;
  logic hit_update;
  logic hit_active;
  logic wr_steer;
  logic wr_chop;
  logic wr_update;
  logic [posc_pkg::DATA_W-1:0] next_rdata;

  assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_req = bus_req & i_wb_we;
  assign word_adr = i_wb_adr & posc_pkg::WORD_MASK;
  assign hit_steer = (word_adr == posc_pkg::OFS_STEER);
  assign hit_chop = (word_adr == posc_pkg::OFS_CHOP);
  assign hit_update = (word_adr == posc_pkg::OFS_UPDATE);
  assign hit_active = (word_adr == posc_pkg::OFS_ACTIVE);
  assign wr_steer = wr_req & hit_steer;
  assign wr_chop = wr_req & hit_chop;
  assign wr_update = wr_req & hit_update;

  // byte-lane merge of write data
  assign next_steer[7:0] = (wr_steer & i_wb_sel[0]) ? i_wb_dat[7:0]
                                                     : output_steer_disable[7:0];
  assign next_steer[8] = (wr_steer & i_wb_sel[1]) ? i_wb_dat[8]
                                                  : output_steer_disable[8];
  assign next_chop[7:0] = (wr_chop & i_wb_sel[0]) ? i_wb_dat[7:0]
                                                   : gate_drive_chop_config[7:0];
  assign next_chop[15:8] = (wr_chop & i_wb_sel[1]) ? i_wb_dat[15:8]
                                                    : gate_drive_chop_config[15:8];
  assign next_double_update = (wr_update & i_wb_sel[0]) ? i_wb_dat[posc_pkg::DBL_UPDATE_BIT]
                                                         : double_update;

  // read words per register, zero extended
  logic [posc_pkg::DATA_W-1:0] rd_steer;
  logic [posc_pkg::DATA_W-1:0] rd_chop;
  logic [posc_pkg::DATA_W-1:0] rd_update;
  logic [posc_pkg::DATA_W-1:0] rd_active;

  assign rd_steer = {23'h000000, output_steer_disable};
  assign rd_chop = {16'h0000, gate_drive_chop_config};
  assign rd_update = {31'h00000000, double_update};
  assign rd_active = {23'h000000, active_steer};

  // read data, unmapped words read zero
  assign next_rdata = hit_steer ? rd_steer
                    : hit_chop ? rd_chop
                    : hit_update ? rd_update
                    : hit_active ? rd_active
                    : 32'h00000000;

  // registers written by software
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      output_steer_disable <= posc_pkg::STEER_RST;
    end else begin
      output_steer_disable <= next_steer;
    end
  end

  // gate drive configuration, in force at once
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gate_drive_chop_config <= posc_pkg::CHOP_RST;
    end else begin
      gate_drive_chop_config <= next_chop;
    end
  end

  // update mode bit
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      double_update <= posc_pkg::UPDATE_RST;
    end else begin
      double_update <= next_double_update;
    end
  end

  // bus answer, one cycle after the request, dropped the cycle after
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= bus_req;
    end
  end

  // read data stands with ack only
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_dat <= bus_req ? next_rdata : 32'h00000000;
    end
  end

  // rising edges of the cycle start and midpoint pulses
  assign sync_rise = i_cycle_sync_pulse & ~sync_prev;
  assign mid_rise = i_cycle_mid_pulse & ~mid_prev;
  assign latch_now = sync_rise | (mid_rise & double_update);

  // cycle start pulse history
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_prev <= 1'b0;
    end else begin
      sync_prev <= i_cycle_sync_pulse;
    end
  end

  // midpoint pulse history
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mid_prev <= 1'b0;
    end else begin
      mid_prev <= i_cycle_mid_pulse;
    end
  end

  // transfer of the shadow into the control in force
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      active_steer <= posc_pkg::STEER_RST;
    end else if (latch_now) begin
      active_steer <= output_steer_disable;
    end
  end

  // crossover bits in force
  logic xover0;
  logic xover1;
  logic xover2;

  assign xover0 = active_steer[posc_pkg::XOVER_PAIR0_BIT];
  assign xover1 = active_steer[posc_pkg::XOVER_PAIR1_BIT];
  assign xover2 = active_steer[posc_pkg::XOVER_PAIR2_BIT];

  // steered signals per pin
  logic steer0_high;
  logic steer0_low;
  logic steer1_high;
  logic steer1_low;
  logic steer2_high;
  logic steer2_low;

  assign steer0_high = xover0 ? i_tu_pair0_low : i_tu_pair0_high;
  assign steer0_low = xover0 ? i_tu_pair0_high : i_tu_pair0_low;
  assign steer1_high = xover1 ? i_tu_pair1_low : i_tu_pair1_high;
  assign steer1_low = xover1 ? i_tu_pair1_high : i_tu_pair1_low;
  assign steer2_high = xover2 ? i_tu_pair2_low : i_tu_pair2_high;
  assign steer2_low = xover2 ? i_tu_pair2_high : i_tu_pair2_low;

  // disable bits in force, one per pin
  logic dis0_high;
  logic dis0_low;
  logic dis1_high;
  logic dis1_low;
  logic dis2_high;
  logic dis2_low;

  assign dis2_high = active_steer[posc_pkg::DIS_PAIR2_HIGH_BIT];
  assign dis2_low = active_steer[posc_pkg::DIS_PAIR2_LOW_BIT];
  assign dis1_high = active_steer[posc_pkg::DIS_PAIR1_HIGH_BIT];
  assign dis1_low = active_steer[posc_pkg::DIS_PAIR1_LOW_BIT];
  assign dis0_high = active_steer[posc_pkg::DIS_PAIR0_HIGH_BIT];
  assign dis0_low = active_steer[posc_pkg::DIS_PAIR0_LOW_BIT];

  // signals after disable, applied on the steered pin signals
  logic gated0_high;
  logic gated0_low;
  logic gated1_high;
  logic gated1_low;
  logic gated2_high;
  logic gated2_low;

  assign gated0_high = dis0_high ? posc_pkg::OUT_OFF : steer0_high;
  assign gated0_low = dis0_low ? posc_pkg::OUT_OFF : steer0_low;
  assign gated1_high = dis1_high ? posc_pkg::OUT_OFF : steer1_high;
  assign gated1_low = dis1_low ? posc_pkg::OUT_OFF : steer1_low;
  assign gated2_high = dis2_high ? posc_pkg::OUT_OFF : steer2_high;
  assign gated2_low = dis2_low ? posc_pkg::OUT_OFF : steer2_low;

  // chopping carrier
  logic carrier;

  posc_chop_carrier u_carrier (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_chop_divider(gate_drive_chop_config[posc_pkg::DIV_MSB:posc_pkg::DIV_LSB]),
    .o_carrier(carrier)
  );

  // chop enables and the gating term of each side
  logic chop_high_en;
  logic chop_low_en;
  logic high_gate;
  logic low_gate;

  assign chop_high_en = gate_drive_chop_config[posc_pkg::CHOP_HIGH_BIT];
  assign chop_low_en = gate_drive_chop_config[posc_pkg::CHOP_LOW_BIT];
  assign high_gate = ~chop_high_en | carrier;
  assign low_gate = ~chop_low_en | carrier;

  // final pin values, inactive phase passes unchanged
  logic next_pair0_high;
  logic next_pair0_low;
  logic next_pair1_high;
  logic next_pair1_low;
  logic next_pair2_high;
  logic next_pair2_low;

  assign next_pair0_high = gated0_high & high_gate;
  assign next_pair1_high = gated1_high & high_gate;
  assign next_pair2_high = gated2_high & high_gate;
  assign next_pair0_low = gated0_low & low_gate;
  assign next_pair1_low = gated1_low & low_gate;
  assign next_pair2_low = gated2_low & low_gate;

  // registered pins
  // pair 0 high-side pin
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pair0_high_pin <= posc_pkg::OUT_OFF;
    end else begin
      o_pair0_high_pin <= next_pair0_high;
    end
  end

  // pair 0 low-side pin
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pair0_low_pin <= posc_pkg::OUT_OFF;
    end else begin
      o_pair0_low_pin <= next_pair0_low;
    end
  end

  // pair 1 high-side pin
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pair1_high_pin <= posc_pkg::OUT_OFF;
    end else begin
      o_pair1_high_pin <= next_pair1_high;
    end
  end

  // pair 1 low-side pin
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pair1_low_pin <= posc_pkg::OUT_OFF;
    end else begin
      o_pair1_low_pin <= next_pair1_low;
    end
  end

  // pair 2 high-side pin
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pair2_high_pin <= posc_pkg::OUT_OFF;
    end else begin
      o_pair2_high_pin <= next_pair2_high;
    end
  end

  // pair 2 low-side pin
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pair2_low_pin <= posc_pkg::OUT_OFF;
    end else begin
      o_pair2_low_pin <= next_pair2_low;
    end
  end
endmodule // posc_top

// *** posc_gate_drv_model.sv ***
// gate driver inputs of a three-phase inverter, gathered as one on/off vector
// assumes active-high pins, order p0h p0l p1h p1l p2h p2l from bit 5 down
`timescale 1ns/10ps
module posc_gate_drv_model (
  // driver inputs
  input wire logic i_p0h,
  input wire logic i_p0l,
  input wire logic i_p1h,
  input wire logic i_p1l,
  input wire logic i_p2h,
  input wire logic i_p2l,
  // switch states seen by the drivers
  output logic [5:0] o_on
);
  assign o_on = {i_p0h, i_p0l, i_p1h, i_p1l, i_p2h, i_p2l};
endmodule // posc_gate_drv_model

// *** posc_top_asserts.sv ***
// port-level checks of the steering and chopping stage
// assumes the single clock and active-high async reset of posc_top
`timescale 1ns/10ps
module posc_top_asserts (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic i_tu_pair0_high,
  input wire logic i_tu_pair0_low,
  input wire logic i_tu_pair1_high,
  input wire logic i_tu_pair1_low,
  input wire logic i_tu_pair2_high,
  input wire logic i_tu_pair2_low,
  input wire logic o_pair0_high_pin,
  input wire logic o_pair0_low_pin,
  input wire logic o_pair1_high_pin,
  input wire logic o_pair1_low_pin,
  input wire logic o_pair2_high_pin,
  input wire logic o_pair2_low_pin
);
  logic touched;
  wire logic [5:0] tu = {i_tu_pair0_high, i_tu_pair0_low, i_tu_pair1_high, i_tu_pair1_low, i_tu_pair2_high,
    i_tu_pair2_low};
  wire logic [5:0] pins = {o_pair0_high_pin, o_pair0_low_pin, o_pair1_high_pin, o_pair1_low_pin,
    o_pair2_high_pin, o_pair2_low_pin};
  // set by the first register write after reset
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) touched <= 1'b0;
    else if (i_wb_cyc && i_wb_stb && i_wb_we) touched <= 1'b1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  a_ack_follows_req: assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
    else $error("request not acked");
  a_ack_needs_req: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  a_rdat_idle_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("read data outside ack");
  a_pins_idle_off: assert property (tu == 6'h00 |=> pins == 6'h00) else $error("pin on without source");
  a_pair0_source: assert property (o_pair0_high_pin || o_pair0_low_pin |-> $past(tu[5] || tu[4]))
    else $error("pair 0 pin from foreign source");
  a_pair1_source: assert property (o_pair1_high_pin || o_pair1_low_pin |-> $past(tu[3] || tu[2]))
    else $error("pair 1 pin from foreign source");
  a_pair2_source: assert property (o_pair2_high_pin || o_pair2_low_pin |-> $past(tu[1] || tu[0]))
    else $error("pair 2 pin from foreign source");
  a_reset_passthru: assert property (!touched |=> pins == $past(tu)) else $error("pins not straight after reset");
endmodule // posc_top_asserts
bind posc_top posc_top_asserts u_posc_top_asserts (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
  .i_tu_pair0_high(i_tu_pair0_high), .i_tu_pair0_low(i_tu_pair0_low), .i_tu_pair1_high(i_tu_pair1_high),
  .i_tu_pair1_low(i_tu_pair1_low), .i_tu_pair2_high(i_tu_pair2_high), .i_tu_pair2_low(i_tu_pair2_low),
  .o_pair0_high_pin(o_pair0_high_pin), .o_pair0_low_pin(o_pair0_low_pin), .o_pair1_high_pin(o_pair1_high_pin),
  .o_pair1_low_pin(o_pair1_low_pin), .o_pair2_high_pin(o_pair2_high_pin), .o_pair2_low_pin(o_pair2_low_pin));

// *** tb_top.sv ***
// self-checking bench of the steering and chopping stage
// assumes posc_pkg offsets and a wishbone ack one cycle after a request
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] ST = posc_pkg::OFS_STEER;
  localparam logic [7:0] CH = posc_pkg::OFS_CHOP;
  logic i_clk = 1'b0, i_sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sync = 1'b0, mid = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [3:0] lanes = 4'hF;
  logic [31:0] dat = 32'h0, rd;
  logic [5:0] tu = 6'h00;
  wire logic ack, p0h, p0l, p1h, p1l, p2h, p2l;
  wire logic [31:0] wdat;
  wire logic [5:0] on;
  int bad_count = 0, n_compared = 0;
  always #2.5 i_clk = ~i_clk;
  posc_top u_posc_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_ack(ack), .o_wb_dat(wdat), .i_tu_pair0_high(tu[5]),
    .i_tu_pair0_low(tu[4]), .i_tu_pair1_high(tu[3]), .i_tu_pair1_low(tu[2]), .i_tu_pair2_high(tu[1]),
    .i_tu_pair2_low(tu[0]), .i_cycle_sync_pulse(sync), .i_cycle_mid_pulse(mid), .o_pair0_high_pin(p0h),
    .o_pair0_low_pin(p0l), .o_pair1_high_pin(p1h), .o_pair1_low_pin(p1l), .o_pair2_high_pin(p2h),
    .o_pair2_low_pin(p2l));
  posc_gate_drv_model u_posc_gate_drv_model (.i_p0h(p0h), .i_p0l(p0l), .i_p1h(p1h), .i_p1l(p1l), .i_p2h(p2h),
    .i_p2l(p2l), .o_on(on));
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pins(input logic [5:0] exp);
    n_compared++;
    if (on !== exp) begin
      bad_count++;
      $display("Error at %0t: pins %b, expected %b", $time, on, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    dat <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("Error at %0t: no ack", $time);
      stop_test();
    end else begin
      rd = wdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic pulse(input bit m);
    @(posedge i_clk);
    if (m) mid <= 1'b1;
    else sync <= 1'b1;
    @(posedge i_clk);
    mid <= 1'b0;
    sync <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic settle(input logic [5:0] t);
    @(posedge i_clk);
    tu <= t;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic t_reset_regs;
    rdchk(ST, 32'h0);
    rdchk(CH, 32'h0);
    settle(6'h3F);
    chk_pins(6'h3F);
    wb(1'b1, ST, 32'hFFFF_FFFF);
    rdchk(ST, 32'h1FF);
    wb(1'b1, posc_pkg::OFS_ACTIVE, 32'hFFFF_FFFF);
    rdchk(posc_pkg::OFS_ACTIVE, 32'h0);
    wb(1'b1, CH, 32'hFFFF_FFFF);
    rdchk(CH, 32'hFFFF);
    lanes = 4'h1;
    wb(1'b1, CH, 32'h0);
    lanes = 4'h2;
    wb(1'b1, ST, 32'h0);
    lanes = 4'hF;
    rdchk(CH, 32'hFF00);
    rdchk(ST, 32'h0FF);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'h0);
    wb(1'b1, CH, 32'h0);
    $display("test reset_regs done");
  endtask
  task automatic t_xover;
    for (int p = 0; p < 3; p++) begin
      wb(1'b1, ST, 32'h100 >> p);
      settle(6'h20 >> (2 * p));
      chk_pins(6'h20 >> (2 * p));
      pulse(1'b0);
      chk_pins(6'h10 >> (2 * p));
    end
    $display("test xover done");
  endtask
  task automatic t_disable;
    settle(6'h3F);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, ST, 32'h1 << i);
      pulse(1'b0);
      chk_pins(6'h3F & ~(6'h01 << (i ^ 1)));
    end
    wb(1'b1, ST, 32'h110);
    pulse(1'b0);
    settle(6'h10);
    chk_pins(6'h00);
    settle(6'h20);
    chk_pins(6'h10);
    $display("test disable done");
  endtask
  task automatic t_double;
    wb(1'b1, ST, 32'h0);
    pulse(1'b0);
    settle(6'h3F);
    wb(1'b1, ST, 32'h3F);
    pulse(1'b1);
    chk_pins(6'h3F);
    wb(1'b1, posc_pkg::OFS_UPDATE, 32'h1);
    pulse(1'b1);
    chk_pins(6'h00);
    wb(1'b1, posc_pkg::OFS_UPDATE, 32'h0);
    wb(1'b1, ST, 32'h0);
    pulse(1'b0);
    chk_pins(6'h3F);
    $display("test double done");
  endtask
  task automatic chop_meas(input logic [31:0] cfg, output int hi, output int lo, output int ris);
    logic prev;
    wb(1'b1, CH, cfg);
    repeat (24) @(posedge i_clk);
    hi = 0;
    lo = 0;
    ris = 0;
    prev = on[5];
    repeat (48) begin
      @(posedge i_clk);
      hi += int'(on[5]);
      lo += int'(on[4]);
      ris += int'(on[5] && !prev);
      prev = on[5];
    end
  endtask
  task automatic t_chop;
    int hi, lo, ris;
    chop_meas(32'h102, hi, lo, ris);
    chk(hi, 24);
    chk(ris, 4);
    chk(lo, 48);
    chop_meas(32'h202, hi, lo, ris);
    chk(lo, 24);
    chk(hi, 48);
    $display("test chop done");
  endtask
  task automatic t_mid_reset;
    wb(1'b1, ST, 32'h1C0);
    pulse(1'b0);
    rdchk(posc_pkg::OFS_ACTIVE, 32'h1C0);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rdchk(ST, 32'h0);
    rdchk(posc_pkg::OFS_ACTIVE, 32'h0);
    rdchk(CH, 32'h0);
    settle(6'h2A);
    chk_pins(6'h2A);
    $display("test mid_reset done");
  endtask
  initial begin
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset_regs();
    t_xover();
    t_disable();
    t_double();
    t_chop();
    t_mid_reset();
    stop_test();
  end
endmodule // tb_top
